// file: core/timer_pkg.sv
/*
  Shared constants and types of the four-timer block: register offsets,
  field positions, reset values and the general-purpose timer modes.
  Assumes a 32-bit AXI4-Lite register port with one register per aligned word.
*/
`default_nettype none

package timer_pkg;

  localparam int unsigned NUM_GP = 3;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CFG_W = 6;
  localparam int unsigned ADDR_W = 8;

  // -------------------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_CORE_PERIOD = 8'h00;
  localparam logic [7:0] OFS_CORE_COUNT = 8'h04;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h08;
  localparam logic [7:0] OFS_GP_CTRL_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
  localparam logic [3:0] GP_BASE_SLOT = 4'h2;
  localparam logic [1:0] GP_FLD_CONFIG = 2'h0;
  localparam logic [1:0] GP_FLD_COUNT = 2'h1;
  localparam logic [1:0] GP_FLD_PERIOD = 2'h2;
  localparam logic [1:0] GP_FLD_WIDTH = 2'h3;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  localparam int unsigned CORE_CTRL_EN_BIT = 0;
  localparam int unsigned CORE_CTRL_PIN_BIT = 1;
  localparam int unsigned CFG_POL_BIT = 2;
  localparam int unsigned GP_RUN_LSB = 4;
  localparam int unsigned IRQ_CORE_BIT = 0;
  localparam int unsigned IRQ_GP_LSB = 1;
  localparam int unsigned IRQ_W = 4;

  // -------------------------------------------------------------------
  // Reset values and responses
  // -------------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [5:0] RST_CFG = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_WAVE = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_WATCHDOG = 2'b11
  } gp_mode_e;

endpackage : timer_pkg

`default_nettype wire

// file: core/gp_timer_if.sv
/*
  Link between the register file and one general-purpose timer.
  Assumes both ends run on the same clock.
*/
`default_nettype none

interface gp_timer_if;
  import timer_pkg::*;
  logic enable;
  gp_mode_e mode;
  logic polarity;
  logic [31:0] period;
  logic [31:0] width;
  logic pin_in;
  logic pin_out;
  logic pin_oe;
  logic [31:0] count;
  logic expire;
  logic cap_strobe;
  logic [31:0] cap_width;
  logic [31:0] cap_period;

  modport ctrl (
    output enable, mode, polarity, period, width, pin_in,
    input pin_out, pin_oe, count, expire, cap_strobe, cap_width, cap_period
  );
  modport unit (
    input enable, mode, polarity, period, width, pin_in,
    output pin_out, pin_oe, count, expire, cap_strobe, cap_width, cap_period
  );
endinterface : gp_timer_if

`default_nettype wire

// file: core/gp_timer.sv
/*
  One general-purpose timer: waveform, width capture or event watchdog.
  Assumes the pin input is synchronous to aclk and settings come from
  the register file through gp_timer_if.
*/
`default_nettype none

module gp_timer (
  input wire logic aclk,
  input wire logic aresetn,
  gp_timer_if.unit bus
);
  import timer_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic [31:0] high_time;
    logic pin_prev;
    logic seen_edge;
    logic pin_out;
    logic pin_oe;
    logic expire;
    logic cap_strobe;
    logic [31:0] cap_width;
    logic [31:0] cap_period;
  } gp_state_s;

  gp_state_s s_reg;
  gp_state_s s_next;
  logic pin_level;

  assign pin_level = bus.pin_in ^ bus.polarity;

  always_comb begin
    s_next = s_reg;
    s_next.expire = 1'b0;
    s_next.cap_strobe = 1'b0;
    s_next.pin_prev = pin_level;
    if (!bus.enable) begin
      s_next.count = RST_WORD;
      s_next.seen_edge = 1'b0;
      s_next.pin_out = 1'b0;
      s_next.pin_oe = 1'b0;
    end else begin
      unique case (bus.mode)
        MODE_OFF: begin
          s_next.count = RST_WORD;
          s_next.pin_out = 1'b0;
          s_next.pin_oe = 1'b0;
        end
        MODE_WAVE: begin
          s_next.pin_oe = 1'b1;
          if (s_reg.count + 32'h1 >= bus.period) begin
            s_next.count = RST_WORD;
            s_next.expire = 1'b1;
          end else begin
            s_next.count = s_reg.count + 32'h1;
          end
          s_next.pin_out = (s_next.count < bus.width) ^ bus.polarity;
        end
        MODE_CAPTURE: begin
          s_next.pin_oe = 1'b0;
          s_next.count = s_reg.count + 32'h1;
          if (pin_level && !s_reg.pin_prev) begin
            s_next.count = 32'h1;
            if (s_reg.seen_edge) begin
              s_next.cap_strobe = 1'b1;
              s_next.expire = 1'b1;
              s_next.cap_period = s_reg.count;
              s_next.cap_width = s_reg.high_time;
            end
            s_next.seen_edge = 1'b1;
          end else if (!pin_level && s_reg.pin_prev) begin
            s_next.high_time = s_reg.count;
          end
        end
        MODE_WATCHDOG: begin
          s_next.pin_oe = 1'b0;
          if (pin_level && !s_reg.pin_prev) begin
            if (s_reg.count + 32'h1 >= bus.period) begin
              s_next.count = RST_WORD;
              s_next.expire = 1'b1;
            end else begin
              s_next.count = s_reg.count + 32'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.pin_out = s_reg.pin_out;
  assign bus.pin_oe = s_reg.pin_oe;
  assign bus.count = s_reg.count;
  assign bus.expire = s_reg.expire;
  assign bus.cap_strobe = s_reg.cap_strobe;
  assign bus.cap_width = s_reg.cap_width;
  assign bus.cap_period = s_reg.cap_period;

endmodule : gp_timer

`default_nettype wire

// file: core/quad_timer_unit.sv
/*
  Four-timer block: a core timer with expiry pin and three general-purpose
  timers, registers on an AXI4-Lite slave, one level interrupt.
  Assumes one clock aclk and pins synchronous to it.
*/
// Register access over AXI4-Lite and the address map were decided locally.

`default_nettype none

module quad_timer_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [timer_pkg::NUM_GP-1:0] gp_pin_in,
  output logic [timer_pkg::NUM_GP-1:0] gp_pin_out,
  output logic [timer_pkg::NUM_GP-1:0] gp_pin_oe,
  output logic core_timer_expiry_pin,
  output logic irq
);
  import timer_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] core_period;
    logic [31:0] core_count;
    logic [1:0] core_ctrl;
    logic expiry_pin;
    logic [NUM_GP-1:0] gp_enable;
    logic [NUM_GP-1:0][CFG_W-1:0] mode_config;
    logic [NUM_GP-1:0][31:0] cycle_length;
    logic [NUM_GP-1:0][31:0] high_duration;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic irq;
  } top_state_s;

  top_state_s s_reg;
  top_state_s s_next;

  logic [NUM_GP-1:0][31:0] gp_count;
  logic [NUM_GP-1:0][31:0] gp_cap_width;
  logic [NUM_GP-1:0][31:0] gp_cap_period;
  logic [NUM_GP-1:0] gp_cap_strobe;
  logic [NUM_GP-1:0] gp_expire;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // ---------------------------------------------------------------------
  // General-purpose timers
  // ---------------------------------------------------------------------
  // three timer instances
  for (genvar g = 0; g < NUM_GP; g++) begin : gen_gp
    gp_timer_if tif();
    assign tif.enable = s_reg.gp_enable[g];
    assign tif.mode = gp_mode_e'(s_reg.mode_config[g][1:0]);
    assign tif.polarity = s_reg.mode_config[g][CFG_POL_BIT];
    assign tif.period = s_reg.cycle_length[g];
    assign tif.width = s_reg.high_duration[g];
    assign tif.pin_in = gp_pin_in[g];
    assign gp_pin_out[g] = tif.pin_out;
    assign gp_pin_oe[g] = tif.pin_oe;
    assign gp_count[g] = tif.count;
    assign gp_expire[g] = tif.expire;
    assign gp_cap_strobe[g] = tif.cap_strobe;
    assign gp_cap_width[g] = tif.cap_width;
    assign gp_cap_period[g] = tif.cap_period;
    gp_timer u_gp (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(tif.unit)
    );
  end

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    logic core_evt;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] clr;
    logic [3:0] slot;
    logic [1:0] fld;
    logic [1:0] idx;
    core_evt = 1'b0;
    events = '0;
    clr = '0;
    slot = 4'h0;
    fld = 2'h0;
    idx = 2'h0;
    s_next = s_reg;

    if (!s_reg.core_ctrl[CORE_CTRL_EN_BIT]) begin
      s_next.core_count = s_reg.core_period;
    end else if (s_reg.core_count == RST_WORD) begin
      s_next.core_count = s_reg.core_period;
      core_evt = 1'b1;
    end else begin
      s_next.core_count = s_reg.core_count - 32'h1;
    end
    s_next.expiry_pin = core_evt && s_reg.core_ctrl[CORE_CTRL_PIN_BIT];

    // Write channel capture
    if (s_axi_awvalid && !s_reg.aw_have) begin
      s_next.awaddr = s_axi_awaddr;
      s_next.aw_have = 1'b1;
    end
    if (s_axi_wvalid && !s_reg.w_have) begin
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
      s_next.w_have = 1'b1;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // Register write
    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      slot = s_reg.awaddr[7:4];
      fld = s_reg.awaddr[3:2];
      idx = 2'(slot - GP_BASE_SLOT);
      unique case ({s_reg.awaddr[7:2], 2'b00})
        OFS_CORE_PERIOD: s_next.core_period = merge_bytes(s_reg.core_period,
                                                          s_reg.wdata, s_reg.wstrb);
        OFS_CORE_CTRL: begin
          if (s_reg.wstrb[0]) begin
            s_next.core_ctrl = s_reg.wdata[1:0];
          end
        end
        OFS_GP_CTRL_STAT: begin
          if (s_reg.wstrb[0]) begin
            s_next.gp_enable = s_reg.wdata[NUM_GP-1:0];
          end
        end
        OFS_IRQ_CLEAR: begin
          if (s_reg.wstrb[0]) begin
            clr = s_reg.wdata[IRQ_W-1:0];
          end
        end
        OFS_IRQ_ENABLE: begin
          if (s_reg.wstrb[0]) begin
            s_next.irq_enable = s_reg.wdata[IRQ_W-1:0];
          end
        end
        default: begin
          if (slot >= GP_BASE_SLOT && slot < GP_BASE_SLOT + 4'(NUM_GP)) begin
            unique case (fld)
              GP_FLD_CONFIG: begin
                if (s_reg.wstrb[0]) begin
                  s_next.mode_config[idx] = s_reg.wdata[CFG_W-1:0];
                end
              end
              GP_FLD_COUNT: s_next.bresp = RESP_SLVERR;
              GP_FLD_PERIOD: s_next.cycle_length[idx] = merge_bytes(
                  s_reg.cycle_length[idx], s_reg.wdata, s_reg.wstrb);
              GP_FLD_WIDTH: s_next.high_duration[idx] = merge_bytes(
                  s_reg.high_duration[idx], s_reg.wdata, s_reg.wstrb);
            endcase
          end else begin
            s_next.bresp = RESP_SLVERR;
          end
        end
      endcase
    end

    for (int i = 0; i < NUM_GP; i++) begin
      if (gp_cap_strobe[i]) begin
        s_next.cycle_length[i] = gp_cap_period[i];
        s_next.high_duration[i] = gp_cap_width[i];
      end
    end

    // Register read
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = RST_WORD;
      slot = s_axi_araddr[7:4];
      fld = s_axi_araddr[3:2];
      idx = 2'(slot - GP_BASE_SLOT);
      unique case ({s_axi_araddr[7:2], 2'b00})
        OFS_CORE_PERIOD: s_next.rdata = s_reg.core_period;
        OFS_CORE_COUNT: s_next.rdata = s_reg.core_count;
        OFS_CORE_CTRL: s_next.rdata = {30'h0, s_reg.core_ctrl};
        OFS_GP_CTRL_STAT: begin
          s_next.rdata[NUM_GP-1:0] = s_reg.gp_enable;
          s_next.rdata[GP_RUN_LSB +: NUM_GP] = gp_pin_oe;
        end
        OFS_IRQ_STATUS: s_next.rdata = {28'h0, s_reg.irq_status};
        OFS_IRQ_CLEAR: s_next.rdata = RST_WORD;
        OFS_IRQ_ENABLE: s_next.rdata = {28'h0, s_reg.irq_enable};
        default: begin
          if (slot >= GP_BASE_SLOT && slot < GP_BASE_SLOT + 4'(NUM_GP)) begin
            unique case (fld)
              GP_FLD_CONFIG: s_next.rdata = {26'h0, s_reg.mode_config[idx]};
              GP_FLD_COUNT: s_next.rdata = gp_count[idx];
              GP_FLD_PERIOD: s_next.rdata = s_reg.cycle_length[idx];
              GP_FLD_WIDTH: s_next.rdata = s_reg.high_duration[idx];
            endcase
          end else begin
            s_next.rresp = RESP_SLVERR;
          end
        end
      endcase
    end

    // timer events to interrupt, set wins over clear
    events[IRQ_CORE_BIT] = core_evt;
    events[IRQ_GP_LSB +: NUM_GP] = gp_expire;
    s_next.irq_status = (s_reg.irq_status & ~clr) | events;
    s_next.irq = |(s_next.irq_status & s_next.irq_enable);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign s_axi_awready = !s_reg.aw_have;
  assign s_axi_wready = !s_reg.w_have;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign core_timer_expiry_pin = s_reg.expiry_pin;
  assign irq = s_reg.irq;

endmodule : quad_timer_unit

`default_nettype wire

// file: test/quad_timer_unit_sva.sv
/*
  Port checker of the four-timer block.
  Assumes it is bound to quad_timer_unit and sees only its ports.
*/
`default_nettype none

module quad_timer_unit_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [timer_pkg::NUM_GP-1:0] gp_pin_oe,
  input wire logic core_timer_expiry_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_wr_done;
    ##2 s_axi_bvalid;
  endsequence
  sequence s_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hfc;
  endsequence

  property p_wr_answer; s_wr_take |-> s_wr_done; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_after; $rose(s_axi_bvalid) |-> !$past(s_axi_wready) && !$past(s_axi_awready);
  endproperty
  a_b_after: assert property (p_b_after) else $error("write answer without take");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_rd_bad; s_rd_bad |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == RST_WORD;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
  property p_expiry; core_timer_expiry_pin |=> !core_timer_expiry_pin; endproperty
  a_expiry: assert property (p_expiry) else $error("expiry pulse too long");
  property p_oe_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_GP_CTRL_STAT
      |=> s_axi_rdata[6:4] == $past(gp_pin_oe);
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("pin drive state misread");
endmodule : quad_timer_unit_chk

bind quad_timer_unit quad_timer_unit_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .gp_pin_oe(gp_pin_oe),
  .core_timer_expiry_pin(core_timer_expiry_pin)
);

`default_nettype wire

// file: test/pin_partner.sv
/*
  Far side of the three timer pins: a square-wave source per pin.
  Assumes the bench sets run and phase lengths; idle pins are pulled up.
*/
`default_nettype none

module pin_partner (
  input wire logic aclk,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] run,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  output logic [2:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt [3];

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (!run[i] || cnt[i] >= hi_len + lo_len - 8'd1) begin
        cnt[i] <= 8'd0;
      end else begin
        cnt[i] <= cnt[i] + 8'd1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe[i] === 1'b1) begin
        pin_level[i] = pin_out[i];
      end else if (run[i]) begin
        pin_level[i] = cnt[i] < hi_len;
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule : pin_partner

`default_nettype wire

// file: test/quad_timer_unit_tb.sv
/*
  Self-checking bench of the four-timer block.
  Assumes pin_partner on the timer pins and the bound port checker.
*/
`default_nettype none

module quad_timer_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, hi_len, lo_len;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, core_timer_expiry_pin, irq;
  logic [2:0] gp_pin_in, gp_pin_out, gp_pin_oe, run;
  int num_errors = 0;
  int n_compared = 0;

  quad_timer_unit u_dut (.*);
  pin_partner u_pins (.aclk(aclk), .pin_oe(gp_pin_oe), .pin_out(gp_pin_out), .run(run),
    .hi_len(hi_len), .lo_len(lo_len), .pin_level(gp_pin_in));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] gp_addr(input logic [3:0] n, input logic [1:0] fld);
    return {GP_BASE_SLOT + n, fld, 2'b00};
  endfunction : gp_addr

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check(r, RESP_OKAY);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, exp);
    check(r, RESP_OKAY);
  endtask : rd_chk

  task automatic wave_hi(output int hi, output int oe);
    hi = 0;
    oe = 0;
    repeat (4) @(posedge aclk);
    repeat (8) begin
      @(posedge aclk);
      hi += gp_pin_out[0];
      oe += gp_pin_oe[0];
    end
  endtask : wave_hi

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 3; n++) begin
      rd_chk(gp_addr(4'(n), GP_FLD_CONFIG), RST_WORD);
      rd_chk(gp_addr(4'(n), GP_FLD_COUNT), RST_WORD);
    end
    rd_chk(OFS_GP_CTRL_STAT, RST_WORD);
    wr(gp_addr(4'h2, GP_FLD_CONFIG), 32'hffff_ffff);
    rd_chk(gp_addr(4'h2, GP_FLD_CONFIG), 32'h0000_003f);
    wr(gp_addr(4'h2, GP_FLD_WIDTH), 32'hffff_ffff);
    rd_chk(gp_addr(4'h2, GP_FLD_WIDTH), 32'hffff_ffff);
    axi_wr(gp_addr(4'h2, GP_FLD_COUNT), 32'h0000_0005, r);
    check(r, RESP_SLVERR);
    rd_chk(gp_addr(4'h2, GP_FLD_COUNT), RST_WORD);
    axi_rd(8'hfc, d, r);
    check(r, RESP_SLVERR);
    check(d, RST_WORD);
  endtask : t_regs

  task automatic t_core();
    int n;
    wr(OFS_CORE_PERIOD, 32'h0000_0009);
    wr(OFS_CORE_CTRL, 32'h0000_0003);
    for (n = 0; !core_timer_expiry_pin && n < 100; n++) @(posedge aclk);
    @(posedge aclk);
    for (n = 1; !core_timer_expiry_pin && n < 100; n++) @(posedge aclk);
    check(n, 10);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0001);
    check(irq, 1'b0);
    wr(OFS_IRQ_ENABLE, 32'h0000_000f);
    repeat (3) @(posedge aclk);
    check(irq, 1'b1);
    wr(OFS_CORE_CTRL, 32'h0000_0001);
    n = 0;
    repeat (30) @(posedge aclk) n += core_timer_expiry_pin;
    check(n, 0);
    wr(OFS_CORE_CTRL, RST_WORD);
    wr(OFS_IRQ_CLEAR, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    check(irq, 1'b0);
    rd_chk(OFS_IRQ_STATUS, RST_WORD);
  endtask : t_core

  task automatic t_wave();
    int hi;
    int oe;
    wr(gp_addr(4'h0, GP_FLD_PERIOD), 32'h0000_0008);
    wr(gp_addr(4'h0, GP_FLD_WIDTH), 32'h0000_0003);
    wr(gp_addr(4'h0, GP_FLD_CONFIG), 32'(MODE_WAVE));
    wr(OFS_GP_CTRL_STAT, 32'h0000_0001);
    wave_hi(hi, oe);
    check(hi, 3);
    check(oe, 8);
    check(gp_pin_oe, 3'b001);
    rd_chk(OFS_GP_CTRL_STAT, 32'h0000_0011);
    wr(gp_addr(4'h0, GP_FLD_CONFIG), 32'(MODE_WAVE) | (32'h1 << CFG_POL_BIT));
    wave_hi(hi, oe);
    check(hi, 5);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_0002);
    wr(OFS_GP_CTRL_STAT, RST_WORD);
    repeat (3) @(posedge aclk);
    check(gp_pin_oe, 3'b000);
  endtask : t_wave

  task automatic t_capture();
    wr(gp_addr(4'h1, GP_FLD_CONFIG), 32'(MODE_CAPTURE));
    wr(gp_addr(4'h2, GP_FLD_PERIOD), 32'h0000_0003);
    wr(gp_addr(4'h2, GP_FLD_CONFIG), 32'(MODE_WATCHDOG));
    wr(OFS_IRQ_CLEAR, 32'h0000_000f);
    hi_len <= 8'd5;
    lo_len <= 8'd7;
    run <= 3'b110;
    wr(OFS_GP_CTRL_STAT, 32'h0000_0006);
    repeat (60) @(posedge aclk);
    check(gp_pin_oe, 3'b000);
    rd_chk(gp_addr(4'h2, GP_FLD_COUNT), 32'h0000_0002);
    rd_chk(gp_addr(4'h1, GP_FLD_WIDTH), 32'h0000_0005);
    rd_chk(gp_addr(4'h1, GP_FLD_PERIOD), 32'h0000_000c);
    rd_chk(OFS_IRQ_STATUS, 32'h0000_000c);
    run <= 3'b000;
  endtask : t_capture

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    run = 3'b000;
    hi_len = 8'd0;
    lo_len = 8'd0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_core();
    t_wave();
    t_capture();
    end_sim();
  end

  initial begin
    #20000;
    num_errors++;
    end_sim();
  end
endmodule : quad_timer_unit_tb

`default_nettype wire
